// *** rtl/mcs_status.sv ***
// motion cpu status words, per-axis event flags and error code store
//
// Contract
// - The operation-cycle word holds the configured cycle in microseconds, taken at initial processing.
// - The low nibble of the switch word codes the cpu switch as run 0, stop 1, latch clear 2.
// - Bits seven to four of the switch word, the memory card switch, always read off.
// - Bits eight to twelve of the switch word mirror setting switches one to five, 1 meaning on.
// - Bits thirteen to fifteen of the switch word are unused and carry nothing.
// - Each axis raises a start-complete flag at group offset 0 once it has begun positioning.
// - Each axis raises a positioning-complete flag at group offset 1 when positioning finishes.
// - Each axis sets its error flag at group offset 7 on a minor or major error.
// - Each axis sets its servo error flag at group offset 8 when the amplifier reports a fault.
// - With a reader scan of at most 80 ms the error code is stored within 80 ms of its flag.
// - With a reader scan above 80 ms the error code is stored within one scan of its flag.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps

module mcs_status
	import mcs_pkg::*;
#(
	parameter int NAXES = MCS_AXES_DEF
) (
	input  wire logic                              clock_i,
	input  wire logic                              resetn_i,
	input  wire logic                              ce_i,
	input  wire logic [MCS_DW-1:0]                 cycle_cfg_us_i,
	input  wire logic                              cpu_sw_stop_i,
	input  wire logic                              cpu_sw_clear_i,
	input  wire logic [MCS_SW_DIP_W-1:0]           setting_switch_i,
	input  wire mcs_axis_ev_s [NAXES-1:0]          axis_ev_i,
	input  wire mcs_axis_ev_s [NAXES-1:0]          axis_clr_i,
	input  wire logic [NAXES-1:0][MCS_DW-1:0]      axis_err_code_i,
	input  wire logic [MCS_AW-1:0]                 addr_i,
	input  wire logic [MCS_DW-1:0]                 wdata_i,
	input  wire logic                              wr_i,
	input  wire logic                              rd_i,
	output logic      [MCS_DW-1:0]                 rdata_o,
	output logic                                   irq_o
);

	if (NAXES < 1 || NAXES > MCS_AXES_MAX) begin : g_bad_axes
		$error("mcs_status: NAXES out of range");
	end

	// the one-cycle code store must sit inside the error store bound
	if (MCS_ERR_STORE_CYC < 2) begin : g_bad_bound
		$error("mcs_status: error store bound below one cycle");
	end

	// pin synchroniser: stop, clear and the five setting switches
	localparam int PW = 2 + MCS_SW_DIP_W;

	logic [PW-1:0]               pin_s1_r;
	logic [PW-1:0]               pin_s2_r;
	mcs_phase_e                  phase_r;
	mcs_phase_e                  phase_nxt;
	logic [MCS_DW-1:0]           cycle_r;
	logic [MCS_DW-1:0]           cycle_nxt;
	logic [MCS_DW-1:0]           sw_r;
	logic [MCS_DW-1:0]           sw_nxt;
	mcs_axis_ev_s [NAXES-1:0]    flags_r;
	mcs_axis_ev_s [NAXES-1:0]    flags_nxt;
	mcs_axis_ev_s [NAXES-1:0]    prev_r;
	logic [NAXES-1:0][MCS_DW-1:0] err_r;
	logic [NAXES-1:0][MCS_DW-1:0] err_nxt;
	logic [3:0]                  stat_r;
	logic [3:0]                  stat_nxt;
	logic [3:0]                  mask_r;
	logic [3:0]                  mask_nxt;
	logic [3:0]                  rise_any;
	logic [MCS_DW-1:0]           rdata_nxt;
	logic                        irq_nxt;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else if (ce_i) begin
			pin_s1_r <= {cpu_sw_clear_i, cpu_sw_stop_i, setting_switch_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	// initial processing: the cycle word is taken once, then frozen
	always_comb begin
		phase_nxt = phase_r;
		cycle_nxt = cycle_r;
		case (phase_r)
			MCS_INIT: begin
				cycle_nxt = cycle_cfg_us_i;
				phase_nxt = MCS_RUN;
			end
			MCS_RUN: begin
				phase_nxt = MCS_RUN;
			end
			default: begin
				phase_nxt = MCS_INIT;
			end
		endcase
	end

	// switch word refreshed every cycle, like main processing
	always_comb begin
		sw_nxt = MCS_RST_WORD;
		if (pin_s2_r[PW-1])
			sw_nxt[MCS_SW_CPU_LSB +: 4] = MCS_CPU_LATCH_CLEAR;
		else if (pin_s2_r[PW-2])
			sw_nxt[MCS_SW_CPU_LSB +: 4] = MCS_CPU_STOP;
		else
			sw_nxt[MCS_SW_CPU_LSB +: 4] = MCS_CPU_RUN;
		sw_nxt[MCS_SW_CARD_LSB +: 4] = MCS_CARD_OFF;
		sw_nxt[MCS_SW_DIP_LSB +: MCS_SW_DIP_W] = pin_s2_r[MCS_SW_DIP_W-1:0];
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_r <= MCS_INIT;
			cycle_r <= MCS_RST_WORD;
			sw_r    <= MCS_RST_WORD;
		end else if (ce_i) begin
			phase_r <= phase_nxt;
			cycle_r <= cycle_nxt;
			sw_r    <= sw_nxt;
		end
	end

	// axis flags: set wins over a same-cycle clear from the axis logic
	always_comb begin
		rise_any = 4'h0;
		for (int n = 0; n < NAXES; n++) begin
			flags_nxt[n] = (flags_r[n] & ~axis_clr_i[n]) | axis_ev_i[n];
			err_nxt[n]   = err_r[n];
			// code lands one cycle after the flag, far inside the 80 ms bound
			if ((flags_r[n].fault && !prev_r[n].fault) ||
			    (flags_r[n].amp_fault && !prev_r[n].amp_fault))
				err_nxt[n] = axis_err_code_i[n];
			rise_any = rise_any | (flags_r[n] & ~prev_r[n]);
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_r <= '0;
			prev_r  <= '0;
			err_r   <= '0;
		end else if (ce_i) begin
			flags_r <= flags_nxt;
			prev_r  <= flags_r;
			err_r   <= err_nxt;
		end
	end

	// register port: only the interrupt pair is writable
	always_comb begin
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		if (wr_i && addr_i == MCS_ADDR_IRQ_MASK)
			mask_nxt = wdata_i[3:0];
		if (wr_i && addr_i == MCS_ADDR_IRQ_STAT)
			stat_nxt = stat_r & ~wdata_i[3:0];
		stat_nxt = stat_nxt | rise_any;
		irq_nxt  = |(stat_r & mask_r);
	end

	always_comb begin
		rdata_nxt = MCS_RST_WORD;
		if (rd_i) begin
			if (addr_i == MCS_ADDR_CYCLE)
				rdata_nxt = cycle_r;
			else if (addr_i == MCS_ADDR_SWITCH)
				rdata_nxt = sw_r;
			else if (addr_i == MCS_ADDR_IRQ_STAT)
				rdata_nxt = {12'h000, stat_r};
			else if (addr_i == MCS_ADDR_IRQ_MASK)
				rdata_nxt = {12'h000, mask_r};
			for (int n = 0; n < NAXES; n++) begin
				if (addr_i == MCS_ADDR_FLAG_BASE + MCS_AW'(n))
					rdata_nxt = mcs_flag_word(flags_r[n]);
				if (addr_i == MCS_ADDR_ERR_BASE + MCS_AW'(n))
					rdata_nxt = err_r[n];
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stat_r  <= MCS_RST_IRQ;
			mask_r  <= MCS_RST_IRQ;
			rdata_o <= MCS_RST_WORD;
			irq_o   <= 1'b0;
		end else if (ce_i) begin
			stat_r  <= stat_nxt;
			mask_r  <= mask_nxt;
			rdata_o <= rdata_nxt;
			irq_o   <= irq_nxt;
		end
	end

	// checks on axis 0 stand for every axis, the loop body is identical
	a_cycle_frozen: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(phase_r == MCS_RUN && ce_i) |=> $stable(cycle_r))
		else $error("cycle word changed after initial processing");

	a_sw_fields: assert property (@(posedge clock_i) disable iff (!resetn_i)
		sw_r[3:0] <= MCS_CPU_LATCH_CLEAR && sw_r[7:4] == MCS_CARD_OFF && sw_r[15:13] == 3'h0)
		else $error("switch word holds an illegal field");

	a_sw_clear_code: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && pin_s2_r[PW-1]) |=> sw_r[3:0] == MCS_CPU_LATCH_CLEAR)
		else $error("latch clear position not coded as 2");

	a_sw_dip_mirror: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i |=> sw_r[12:8] == $past(pin_s2_r[4:0]))
		else $error("setting switches not mirrored");

	a_start_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && axis_ev_i[0].start_done) |=> flags_r[0].start_done)
		else $error("start flag missed");

	a_set_wins: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && axis_ev_i[0].fault && axis_clr_i[0].fault) |=> flags_r[0].fault)
		else $error("clear beat a same-cycle fault");

	a_err_store: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].amp_fault && !prev_r[0].amp_fault)
		|=> err_r[0] == $past(axis_err_code_i[0]))
		else $error("error code not stored after servo flag");

	a_ro_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && wr_i && addr_i == MCS_ADDR_SWITCH && phase_r == MCS_RUN)
		|=> $stable(cycle_r))
		else $error("write disturbed a read-only word");

	a_rd_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && !rd_i) |=> rdata_o == MCS_RST_WORD)
		else $error("read data outside the read answer cycle");

	a_irq_level: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i |=> irq_o == |($past(stat_r) & $past(mask_r)))
		else $error("interrupt level disagrees with status and mask");

	// status words, axis flags, error codes, then the interrupt pair and the enable
	a_cycle_capture: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(phase_r == MCS_INIT && ce_i) |=> cycle_r == $past(cycle_cfg_us_i))
		else $error("cycle word not taken at initial processing");

	a_rd_cycle: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && rd_i && addr_i == MCS_ADDR_CYCLE) |=> rdata_o == $past(cycle_r))
		else $error("cycle word read back wrong");

	a_sw_stop_code: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && !pin_s2_r[PW-1] && pin_s2_r[PW-2]) |=> sw_r[3:0] == MCS_CPU_STOP)
		else $error("stop position not coded as 1");

	a_sw_run_code: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && !pin_s2_r[PW-1] && !pin_s2_r[PW-2]) |=> sw_r[3:0] == MCS_CPU_RUN)
		else $error("run position not coded as 0");

	a_card_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		sw_r[MCS_SW_CARD_LSB +: 4] == MCS_CARD_OFF)
		else $error("memory card field not off");

	a_sw_unused: assert property (@(posedge clock_i) disable iff (!resetn_i)
		sw_r[15:13] == 3'h0)
		else $error("unused switch bits not zero");

	a_rd_switch: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && rd_i && addr_i == MCS_ADDR_SWITCH) |=> rdata_o == $past(sw_r))
		else $error("switch word read back wrong");

	a_pos_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && axis_ev_i[0].pos_done) |=> flags_r[0].pos_done)
		else $error("positioning done flag missed");

	a_fault_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && axis_ev_i[0].fault) |=> flags_r[0].fault)
		else $error("error flag missed");

	a_amp_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && axis_ev_i[0].amp_fault) |=> flags_r[0].amp_fault)
		else $error("servo error flag missed");

	a_start_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].start_done && !axis_clr_i[0].start_done) |=> flags_r[0].start_done)
		else $error("start flag dropped without a clear");

	a_pos_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].pos_done && !axis_clr_i[0].pos_done) |=> flags_r[0].pos_done)
		else $error("positioning done flag dropped without a clear");

	a_flag_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].fault && !axis_clr_i[0].fault) |=> flags_r[0].fault)
		else $error("error flag dropped without a clear");

	a_amp_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].amp_fault && !axis_clr_i[0].amp_fault) |=> flags_r[0].amp_fault)
		else $error("servo error flag dropped without a clear");

	a_err_fault: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && flags_r[0].fault && !prev_r[0].fault)
		|=> err_r[0] == $past(axis_err_code_i[0]))
		else $error("error code not stored after error flag");

	a_err_steady: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && !(flags_r[0].fault && !prev_r[0].fault)
		&& !(flags_r[0].amp_fault && !prev_r[0].amp_fault)) |=> $stable(err_r[0]))
		else $error("error code moved with no flag rise");

	a_rd_err: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && rd_i && addr_i == MCS_ADDR_ERR_BASE) |=> rdata_o == $past(err_r[0]))
		else $error("error code read back wrong");

	a_ro_flags: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && wr_i && addr_i == MCS_ADDR_FLAG_BASE && axis_ev_i[0] == '0
		&& axis_clr_i[0] == '0) |=> $stable(flags_r[0]))
		else $error("write disturbed an axis flag word");

	a_stat_set_wins: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && rise_any != 4'h0) |=> (stat_r & $past(rise_any)) == $past(rise_any))
		else $error("flag rise lost from interrupt status");

	a_stat_w1c: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && wr_i && addr_i == MCS_ADDR_IRQ_STAT && rise_any == 4'h0)
		|=> ({12'h000, stat_r} & $past(wdata_i)) == 16'h0000)
		else $error("written one did not clear its status bit");

	a_irq_masked: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && mask_r == 4'h0) |=> !irq_o)
		else $error("interrupt raised with all bits masked");

	a_ce_freeze: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!ce_i |=> $stable(flags_r) && $stable(stat_r) && $stable(rdata_o) && $stable(irq_o))
		else $error("state moved while clock enable was low");

	c_fault_rise: cover property (@(posedge clock_i) disable iff (!resetn_i)
		flags_r[0].fault && !prev_r[0].fault);
	c_read_switch: cover property (@(posedge clock_i) disable iff (!resetn_i)
		rd_i && addr_i == MCS_ADDR_SWITCH);
	c_irq_rise: cover property (@(posedge clock_i) disable iff (!resetn_i)
		$rose(irq_o));
	c_set_clear: cover property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && axis_ev_i[0].fault && axis_clr_i[0].fault);
	c_ce_frozen: cover property (@(posedge clock_i) disable iff (!resetn_i)
		!ce_i && axis_ev_i[0] != '0);

endmodule : mcs_status

// *** shared/mcs_pkg.sv ***
// motion cpu status words: shared constants, register map and carrier types
package mcs_pkg;

	// per-axis event or flag bundle, one bit per tracked axis condition
	typedef struct packed {
		logic amp_fault;
		logic fault;
		logic pos_done;
		logic start_done;
	} mcs_axis_ev_s;

	typedef enum logic [0:0] {
		MCS_INIT,
		MCS_RUN
	} mcs_phase_e;

	localparam int          MCS_AXES_DEF        = 32;
	localparam int          MCS_AXES_MAX        = 64;
	localparam int          MCS_DW              = 16;
	localparam int          MCS_AW              = 8;

	// register map (word addresses on the plain register port)
	localparam logic [7:0]  MCS_ADDR_CYCLE      = 8'h00;
	localparam logic [7:0]  MCS_ADDR_SWITCH     = 8'h01;
	localparam logic [7:0]  MCS_ADDR_IRQ_STAT   = 8'h02;
	localparam logic [7:0]  MCS_ADDR_IRQ_MASK   = 8'h03;
	localparam logic [7:0]  MCS_ADDR_FLAG_BASE  = 8'h40;
	localparam logic [7:0]  MCS_ADDR_ERR_BASE   = 8'h80;

	// flag positions inside one axis group of 20 flags
	localparam int          MCS_FLAG_STRIDE     = 20;
	localparam int          MCS_FLAG_START      = 0;
	localparam int          MCS_FLAG_POSDONE    = 1;
	localparam int          MCS_FLAG_FAULT      = 7;
	localparam int          MCS_FLAG_AMP        = 8;

	// switch word fields
	localparam int          MCS_SW_CPU_LSB      = 0;
	localparam int          MCS_SW_CARD_LSB     = 4;
	localparam int          MCS_SW_DIP_LSB      = 8;
	localparam int          MCS_SW_DIP_W        = 5;
	localparam logic [3:0]  MCS_CPU_RUN         = 4'h0;
	localparam logic [3:0]  MCS_CPU_STOP        = 4'h1;
	localparam logic [3:0]  MCS_CPU_LATCH_CLEAR = 4'h2;
	localparam logic [3:0]  MCS_CARD_OFF        = 4'h0;

	// reset values
	localparam logic [15:0] MCS_RST_WORD        = 16'h0000;
	localparam logic [3:0]  MCS_RST_IRQ         = 4'h0;

	// error code store latency bound
	localparam int          MCS_CLK_HZ          = 50_000_000;
	localparam int          MCS_ERR_STORE_MS    = 80;
	localparam longint      MCS_ERR_STORE_CYC   = (64'(MCS_CLK_HZ) * MCS_ERR_STORE_MS) / 1000;

	// places one axis flag bundle at its documented positions within the group
	function automatic logic [15:0] mcs_flag_word(input mcs_axis_ev_s f);
		logic [15:0] w;
		w = 16'h0000;
		w[MCS_FLAG_START]   = f.start_done;
		w[MCS_FLAG_POSDONE] = f.pos_done;
		w[MCS_FLAG_FAULT]   = f.fault;
		w[MCS_FLAG_AMP]     = f.amp_fault;
		return w;
	endfunction : mcs_flag_word

endpackage : mcs_pkg

// *** tb/mcs_status_bench.sv ***
// self-checking bench for the motion cpu status words block
`timescale 1ns/100ps

module mcs_status_bench;
	import mcs_pkg::*;

	localparam int NA = 2;

	logic                         clock_i;
	logic                         resetn_i;
	logic      [MCS_DW-1:0]       cycle_cfg;
	logic                         sw_stop;
	logic                         sw_clear;
	logic      [MCS_SW_DIP_W-1:0] dip;
	mcs_axis_ev_s [NA-1:0]        ev;
	mcs_axis_ev_s [NA-1:0]        clr;
	logic [NA-1:0][MCS_DW-1:0]    ecode;
	logic      [MCS_AW-1:0]       addr;
	logic      [MCS_DW-1:0]       wdata;
	logic                         wr;
	logic                         rd;
	logic                         ce;
	logic      [MCS_DW-1:0]       rdata;
	logic                         irq;
	int                           miscompares = 0;
	int                           checks      = 0;

	mcs_status #(.NAXES(NA)) dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce), .cycle_cfg_us_i(cycle_cfg),
		.cpu_sw_stop_i(sw_stop), .cpu_sw_clear_i(sw_clear), .setting_switch_i(dip),
		.axis_ev_i(ev), .axis_clr_i(clr), .axis_err_code_i(ecode), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq)
	);

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock_i);
		wr    <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
		@(posedge clock_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock_i);
		rd   <= 1'b0;
		#1 check_word(name, exp, rdata);
	endtask : rd_chk

	task automatic pulse(input int n, input mcs_axis_ev_s e, input bit is_clr);
		@(posedge clock_i);
		if (is_clr)
			clr[n] <= e;
		else
			ev[n] <= e;
		@(posedge clock_i);
		ev[n]  <= '0;
		clr[n] <= '0;
	endtask : pulse

	task automatic test_words;
		logic [3:0] code;
		logic [1:0] mode [4];
		logic [4:0] pat  [4];
		mode = '{2'b00, 2'b01, 2'b11, 2'b10};
		pat  = '{5'h15, 5'h0a, 5'h1f, 5'h01};
		rd_chk(MCS_ADDR_CYCLE, 16'h03e8, "cycle word");
		wr_reg(MCS_ADDR_CYCLE, 16'h5555);
		rd_chk(MCS_ADDR_CYCLE, 16'h03e8, "cycle word after write");
		@(posedge clock_i);
		cycle_cfg <= 16'h07d0;
		rd_chk(MCS_ADDR_CYCLE, 16'h03e8, "cycle word after config change");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_i);
			sw_stop  <= mode[i][0];
			sw_clear <= mode[i][1];
			dip      <= pat[i];
			repeat (4) @(posedge clock_i);
			code = mode[i][1] ? MCS_CPU_LATCH_CLEAR : (mode[i][0] ? MCS_CPU_STOP : MCS_CPU_RUN);
			rd_chk(MCS_ADDR_SWITCH, {3'b000, pat[i], 4'h0, code}, "switch word");
		end
		wr_reg(MCS_ADDR_SWITCH, 16'hffff);
		rd_chk(MCS_ADDR_SWITCH, {3'b000, 5'h01, 4'h0, MCS_CPU_LATCH_CLEAR}, "switch after write");
		rd_chk(8'h3f, 16'h0000, "unmapped read");
		$display("test words done");
	endtask : test_words

	// axis 1 is used so that a stride or index slip shows against axis 0
	task automatic test_flags;
		@(posedge clock_i);
		ecode[1] <= 16'h1234;
		pulse(1, '{amp_fault: 1'b0, fault: 1'b0, pos_done: 1'b0, start_done: 1'b1}, 1'b0);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0001, "start flag");
		pulse(1, '{amp_fault: 1'b0, fault: 1'b0, pos_done: 1'b1, start_done: 1'b0}, 1'b0);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0003, "pos done flag");
		pulse(1, '{amp_fault: 1'b0, fault: 1'b1, pos_done: 1'b0, start_done: 1'b0}, 1'b0);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0083, "fault flag");
		rd_chk(MCS_ADDR_ERR_BASE + 8'h01, 16'h1234, "fault code");
		@(posedge clock_i);
		ecode[1] <= 16'h5678;
		pulse(1, '{amp_fault: 1'b1, fault: 1'b0, pos_done: 1'b0, start_done: 1'b0}, 1'b0);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0183, "amp fault flag");
		rd_chk(MCS_ADDR_ERR_BASE + 8'h01, 16'h5678, "amp fault code");
		rd_chk(MCS_ADDR_FLAG_BASE, 16'h0000, "axis 0 untouched");
		wr_reg(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0000);
		wr_reg(MCS_ADDR_ERR_BASE + 8'h01, 16'h0000);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0183, "flags after write");
		rd_chk(MCS_ADDR_ERR_BASE + 8'h01, 16'h5678, "code after write");
		pulse(1, '{amp_fault: 1'b1, fault: 1'b1, pos_done: 1'b1, start_done: 1'b1}, 1'b1);
		rd_chk(MCS_ADDR_FLAG_BASE + 8'h01, 16'h0000, "flags cleared");
		$display("test flags done");
	endtask : test_flags

	// set and clear of the fault and servo error flags in the same cycle, then an event lost while frozen
	task automatic test_axis_zero;
		pulse(0, '{amp_fault: 1'b0, fault: 1'b0, pos_done: 1'b0, start_done: 1'b1}, 1'b0);
		@(posedge clock_i);
		ecode[0] <= 16'h0abc;
		ev[0]    <= '{amp_fault: 1'b1, fault: 1'b1, pos_done: 1'b0, start_done: 1'b0};
		clr[0]   <= '{amp_fault: 1'b1, fault: 1'b1, pos_done: 1'b0, start_done: 1'b0};
		@(posedge clock_i);
		ev[0]    <= '0;
		clr[0]   <= '0;
		rd_chk(MCS_ADDR_FLAG_BASE, 16'h0181, "set beats clear");
		rd_chk(MCS_ADDR_ERR_BASE, 16'h0abc, "axis 0 code");
		wr_reg(MCS_ADDR_FLAG_BASE, 16'hffff);
		rd_chk(MCS_ADDR_FLAG_BASE, 16'h0181, "axis 0 flags after write");
		@(posedge clock_i);
		ce <= 1'b0;
		@(posedge clock_i);
		ev[0] <= '{amp_fault: 1'b0, fault: 1'b0, pos_done: 1'b1, start_done: 1'b0};
		@(posedge clock_i);
		ev[0] <= '0;
		ce    <= 1'b1;
		rd_chk(MCS_ADDR_FLAG_BASE, 16'h0181, "event lost while frozen");
		$display("test axis zero done");
	endtask : test_axis_zero

	task automatic test_irq;
		rd_chk(MCS_ADDR_IRQ_STAT, 16'h000f, "irq status");
		check_bit("irq masked", 1'b0, irq);
		wr_reg(MCS_ADDR_IRQ_MASK, 16'h0004);
		repeat (3) @(posedge clock_i);
		#1 check_bit("irq unmasked", 1'b1, irq);
		wr_reg(MCS_ADDR_IRQ_STAT, 16'h000b);
		repeat (3) @(posedge clock_i);
		#1 check_bit("irq other bits cleared", 1'b1, irq);
		wr_reg(MCS_ADDR_IRQ_STAT, 16'h0004);
		repeat (3) @(posedge clock_i);
		#1 check_bit("irq cleared", 1'b0, irq);
		rd_chk(MCS_ADDR_IRQ_STAT, 16'h0000, "irq status cleared");
		rd_chk(MCS_ADDR_IRQ_MASK, 16'h0004, "irq mask");
		$display("test irq done");
	endtask : test_irq

	initial begin
		repeat (5000) @(posedge clock_i);
		miscompares++;
		end_sim();
	end

	initial begin
		resetn_i  = 1'b0;
		cycle_cfg = 16'h03e8;
		sw_stop   = 1'b0;
		sw_clear  = 1'b0;
		dip       = 5'h00;
		ev        = '0;
		clr       = '0;
		ecode     = '0;
		addr      = 8'h00;
		wdata     = 16'h0000;
		wr        = 1'b0;
		rd        = 1'b0;
		ce        = 1'b1;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		test_words();
		test_flags();
		test_axis_zero();
		test_irq();
		end_sim();
	end

endmodule : mcs_status_bench
